// >>> hw/motor_start_defs.svh
// Constants of the motor start sequencer: widths, reset values and timing.
`ifndef MOTOR_START_DEFS_SVH
`define MOTOR_START_DEFS_SVH
`define SEQ_SPEED_W 16
`define SEQ_POS_W 16
`define SEQ_DUR_W 16
`define SEQ_CURR_W 12
`define SEQ_CLK_PERIOD_NS 20
`define SEQ_TICK_PERIOD_NS 1000000
`define SEQ_TICK_CYCLES (`SEQ_TICK_PERIOD_NS / `SEQ_CLK_PERIOD_NS)
`define SEQ_SPEED_RST 16'h0000
`define SEQ_STARTUP_ALIGN 2'h0
`define SEQ_STARTUP_DOUBLE_ALIGN 2'h1
`define SEQ_STARTUP_POS_DETECT 2'h2
`define SEQ_STARTUP_SLOW_CYCLE 2'h3
`endif

// >>> hw/motor_start_pkg.sv
// Types shared by the motor start sequencer files.
package motor_start_pkg;
   typedef enum logic [3:0] {
      ST_POWER_ON = 4'h0,
      ST_SLEEP = 4'h1,
      ST_STANDBY = 4'h2,
      ST_DETECT = 4'h3,
      ST_FWD_CHECK = 4'h4,
      ST_REV_CHECK = 4'h5,
      ST_COAST_CHECK = 4'h6,
      ST_COAST = 4'h7,
      ST_BRAKE_CHECK = 4'h8,
      ST_BRAKE = 4'h9,
      ST_STARTUP = 4'hA,
      ST_OPEN_LOOP = 4'hB,
      ST_REV_CLOSED = 4'hC,
      ST_REV_OPEN = 4'hD,
      ST_CLOSED_LOOP = 4'hE
   } seq_state_type;
   typedef struct packed {
      logic force_on;
      logic [2:0] high_on;
      logic [2:0] low_on;
   } gate_ctrl_type;
   typedef struct packed {
      logic start;
      logic [1:0] method;
   } startup_cmd_type;
endpackage

// >>> hw/duration_timer.sv
// Millisecond countdown timer with its own tick divider.
`timescale 1ns/1ps
`include "motor_start_defs.svh"
module duration_timer #(
   parameter int TICK_CYCLES = `SEQ_TICK_CYCLES,
   parameter int DUR_W = `SEQ_DUR_W
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_start,
   input wire logic [DUR_W-1:0] i_duration,
   output logic o_expired
);
   localparam int DIV_W = $clog2(TICK_CYCLES + 1);
   logic [DIV_W-1:0] div_reg;
   logic [DUR_W-1:0] count_reg;
   logic armed_reg;
   logic tick;

   generate
      if (TICK_CYCLES < 2 || DUR_W < 1) begin : g_bad
         $error("duration_timer: unsupported parameters");
      end
   endgenerate

   // The divider restarts with the timer so that every period is whole.
   assign tick = (div_reg == DIV_W'(TICK_CYCLES - 1));

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || i_start || tick) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + DIV_W'(1);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         count_reg <= '0;
         armed_reg <= 1'b0;
      end else if (i_start) begin
         count_reg <= i_duration;
         armed_reg <= 1'b1;
      end else if (armed_reg && tick && count_reg != '0) begin
         count_reg <= count_reg - DUR_W'(1);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || i_start) begin
         o_expired <= 1'b0;
      end else begin
         o_expired <= armed_reg && (count_reg == '0);
      end
   end
endmodule

// >>> hw/motor_start_sequencer.sv
// Start sequencer that picks how a sensorless three-phase motor is started.
`timescale 1ns/1ps
`include "motor_start_defs.svh"
module motor_start_sequencer #(
   parameter int TICK_CYCLES = `SEQ_TICK_CYCLES,
   parameter int SPEED_W = `SEQ_SPEED_W,
   parameter int POS_W = `SEQ_POS_W,
   parameter int DUR_W = `SEQ_DUR_W,
   parameter int CURR_W = `SEQ_CURR_W
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [SPEED_W-1:0] i_speed_target,
   input wire logic i_cmd_dir_reverse,
   input wire logic i_power_state_select,
   input wire logic i_speed_wake_level,
   input wire logic i_initial_detect_enable,
   input wire logic i_forward_catch_enable,
   input wire logic i_counter_rotation_drive_enable,
   input wire logic i_coast_enable,
   input wire logic i_brake_enable,
   input wire logic i_brake_type_select,
   input wire logic i_brake_switch_side_select,
   input wire logic i_counter_rotation_param_select,
   input wire logic [1:0] i_startup_method_select,
   input wire logic [SPEED_W-1:0] i_forward_catch_speed_threshold,
   input wire logic [SPEED_W-1:0] i_loop_handoff_speed_threshold,
   input wire logic [SPEED_W-1:0] i_loop_handoff_speed_level,
   input wire logic [DUR_W-1:0] i_coast_duration,
   input wire logic [DUR_W-1:0] i_brake_duration,
   input wire logic [DUR_W-1:0] i_brake_current_settle_time,
   input wire logic [CURR_W-1:0] i_brake_current_level,
   input wire logic [CURR_W-1:0] i_phase_current_peak,
   input wire logic i_detect_done,
   input wire logic [SPEED_W-1:0] i_detect_speed,
   input wire logic [POS_W-1:0] i_detect_position,
   input wire logic i_detect_dir_reverse,
   input wire logic i_startup_done,
   input wire logic [SPEED_W-1:0] i_speed_estimate,
   input wire logic i_estimate_dir_reverse,
   output motor_start_pkg::seq_state_type o_state,
   output logic [SPEED_W-1:0] o_speed_target,
   output logic o_sleep,
   output logic o_standby,
   output logic o_detect_start,
   output logic o_seed_load,
   output logic [SPEED_W-1:0] o_seed_speed,
   output logic [POS_W-1:0] o_seed_position,
   output motor_start_pkg::gate_ctrl_type o_gate,
   output motor_start_pkg::startup_cmd_type o_startup,
   output logic o_foc_run,
   output logic o_open_loop,
   output logic o_ramp_decel,
   output logic o_use_reverse_params
);
   motor_start_pkg::seq_state_type state_reg;
   motor_start_pkg::seq_state_type state_next;
   logic target_zero;
   logic spin_reverse;
   logic coast_start;
   logic brake_start;
   logic current_high;
   logic dur_expired;
   logic settle_expired;
   logic brake_done;

   generate
      if (SPEED_W < 2 || POS_W < 1 || CURR_W < 1 || TICK_CYCLES < 2) begin : g_bad
         $error("motor_start_sequencer: unsupported parameters");
      end
   endgenerate

   assign target_zero = (o_speed_target == '0);
   // Direction is judged against the command, not against a fixed sense.
   assign spin_reverse = i_detect_dir_reverse ^ i_cmd_dir_reverse;
   assign current_high = (i_phase_current_peak >= i_brake_current_level);
   assign coast_start = (state_reg == motor_start_pkg::ST_COAST_CHECK) && i_coast_enable;
   assign brake_start = (state_reg == motor_start_pkg::ST_BRAKE_CHECK) && i_brake_enable;

   // One timer serves coast and brake, which never overlap.
   duration_timer #(
      .TICK_CYCLES(TICK_CYCLES),
      .DUR_W(DUR_W)
   ) u_dur_timer (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_start(coast_start || brake_start),
      .i_duration(coast_start ? i_coast_duration : i_brake_duration),
      .o_expired(dur_expired)
   );

   // Any current at or above the level restarts the settle window.
   duration_timer #(
      .TICK_CYCLES(TICK_CYCLES),
      .DUR_W(DUR_W)
   ) u_settle_timer (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_start(brake_start || current_high),
      .i_duration(i_brake_current_settle_time),
      .o_expired(settle_expired)
   );

   // The timeout ends a current brake even if the current never settles.
   assign brake_done = dur_expired || (i_brake_type_select && settle_expired);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         motor_start_pkg::ST_POWER_ON: begin
            if (i_power_state_select && !i_speed_wake_level) begin
               state_next = motor_start_pkg::ST_SLEEP;
            end else begin
               state_next = motor_start_pkg::ST_STANDBY;
            end
         end
         motor_start_pkg::ST_SLEEP, motor_start_pkg::ST_STANDBY: begin
            if (!target_zero) begin
               if (i_initial_detect_enable) begin
                  state_next = motor_start_pkg::ST_DETECT;
               end else begin
                  state_next = motor_start_pkg::ST_BRAKE_CHECK;
               end
            end
         end
         motor_start_pkg::ST_DETECT: begin
            if (i_detect_done) begin
               if (spin_reverse) begin
                  state_next = motor_start_pkg::ST_REV_CHECK;
               end else begin
                  state_next = motor_start_pkg::ST_FWD_CHECK;
               end
            end
         end
         motor_start_pkg::ST_FWD_CHECK: begin
            if (!i_forward_catch_enable) begin
               state_next = motor_start_pkg::ST_COAST_CHECK;
            end else if (o_seed_speed > i_forward_catch_speed_threshold) begin
               state_next = motor_start_pkg::ST_CLOSED_LOOP;
            end else begin
               state_next = motor_start_pkg::ST_OPEN_LOOP;
            end
         end
         motor_start_pkg::ST_REV_CHECK: begin
            // Reached only after detection saw reverse spin.
            if (!i_counter_rotation_drive_enable) begin
               state_next = motor_start_pkg::ST_COAST_CHECK;
            end else if (o_seed_speed > i_loop_handoff_speed_threshold) begin
               state_next = motor_start_pkg::ST_REV_CLOSED;
            end else begin
               state_next = motor_start_pkg::ST_REV_OPEN;
            end
         end
         motor_start_pkg::ST_COAST_CHECK: begin
            if (i_coast_enable) begin
               state_next = motor_start_pkg::ST_COAST;
            end else begin
               state_next = motor_start_pkg::ST_BRAKE_CHECK;
            end
         end
         motor_start_pkg::ST_COAST: begin
            if (dur_expired) begin
               state_next = motor_start_pkg::ST_BRAKE_CHECK;
            end
         end
         motor_start_pkg::ST_BRAKE_CHECK: begin
            if (i_brake_enable) begin
               state_next = motor_start_pkg::ST_BRAKE;
            end else begin
               state_next = motor_start_pkg::ST_STARTUP;
            end
         end
         motor_start_pkg::ST_BRAKE: begin
            if (brake_done) begin
               state_next = motor_start_pkg::ST_STARTUP;
            end
         end
         motor_start_pkg::ST_STARTUP: begin
            if (i_startup_done) begin
               state_next = motor_start_pkg::ST_OPEN_LOOP;
            end
         end
         motor_start_pkg::ST_REV_CLOSED: begin
            if (i_speed_estimate <= i_loop_handoff_speed_threshold) begin
               state_next = motor_start_pkg::ST_REV_OPEN;
            end
         end
         motor_start_pkg::ST_REV_OPEN, motor_start_pkg::ST_OPEN_LOOP: begin
            // Closing the loop waits until the rotor turns the commanded way.
            if (!(i_estimate_dir_reverse ^ i_cmd_dir_reverse)
                && i_speed_estimate > i_loop_handoff_speed_level) begin
               state_next = motor_start_pkg::ST_CLOSED_LOOP;
            end
         end
         motor_start_pkg::ST_CLOSED_LOOP: begin
            state_next = motor_start_pkg::ST_CLOSED_LOOP;
         end
         default: begin
            state_next = motor_start_pkg::ST_POWER_ON;
         end
      endcase
      // A zero command stops the motor from any running state.
      if (target_zero && state_reg != motor_start_pkg::ST_POWER_ON
          && state_reg != motor_start_pkg::ST_SLEEP
          && state_reg != motor_start_pkg::ST_STANDBY) begin
         state_next = motor_start_pkg::ST_STANDBY;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state_reg <= motor_start_pkg::ST_POWER_ON;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || state_reg == motor_start_pkg::ST_POWER_ON) begin
         o_speed_target <= SPEED_W'(`SEQ_SPEED_RST);
      end else begin
         o_speed_target <= i_speed_target;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_state <= motor_start_pkg::ST_POWER_ON;
         o_sleep <= 1'b0;
         o_standby <= 1'b0;
      end else begin
         o_state <= state_next;
         o_sleep <= (state_next == motor_start_pkg::ST_SLEEP);
         o_standby <= (state_next == motor_start_pkg::ST_STANDBY);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_detect_start <= 1'b0;
         o_seed_load <= 1'b0;
         o_seed_speed <= '0;
         o_seed_position <= '0;
      end else begin
         o_detect_start <= (state_next == motor_start_pkg::ST_DETECT)
                           && (state_reg != motor_start_pkg::ST_DETECT);
         o_seed_load <= (state_reg == motor_start_pkg::ST_FWD_CHECK)
                        && (state_next == motor_start_pkg::ST_CLOSED_LOOP);
         if (state_reg == motor_start_pkg::ST_DETECT && i_detect_done) begin
            o_seed_speed <= i_detect_speed;
            o_seed_position <= i_detect_position;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_gate <= '0;
      end else if (state_next == motor_start_pkg::ST_COAST) begin
         o_gate <= '{force_on: 1'b1, high_on: 3'h0, low_on: 3'h0};
      end else if (state_next == motor_start_pkg::ST_BRAKE) begin
         // High-side braking is only offered for the timed brake.
         if (!i_brake_type_select && i_brake_switch_side_select) begin
            o_gate <= '{force_on: 1'b1, high_on: 3'h7, low_on: 3'h0};
         end else begin
            o_gate <= '{force_on: 1'b1, high_on: 3'h0, low_on: 3'h7};
         end
      end else begin
         o_gate <= '0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_startup <= '0;
      end else begin
         o_startup.start <= (state_next == motor_start_pkg::ST_STARTUP)
                            && (state_reg != motor_start_pkg::ST_STARTUP);
         o_startup.method <= i_startup_method_select;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_foc_run <= 1'b0;
         o_open_loop <= 1'b0;
         o_ramp_decel <= 1'b0;
         o_use_reverse_params <= 1'b0;
      end else begin
         o_foc_run <= (state_next == motor_start_pkg::ST_CLOSED_LOOP)
                      || (state_next == motor_start_pkg::ST_REV_CLOSED);
         o_open_loop <= (state_next == motor_start_pkg::ST_OPEN_LOOP)
                        || (state_next == motor_start_pkg::ST_REV_OPEN);
         o_ramp_decel <= (state_next == motor_start_pkg::ST_REV_CLOSED)
                         || ((state_next == motor_start_pkg::ST_REV_OPEN)
                             && (i_estimate_dir_reverse ^ i_cmd_dir_reverse));
         o_use_reverse_params <= i_counter_rotation_param_select
                                 && ((state_next == motor_start_pkg::ST_REV_CLOSED)
                                 || (state_next == motor_start_pkg::ST_REV_OPEN));
      end
   end

   a_rest_after_init: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      $past(state_reg) == motor_start_pkg::ST_POWER_ON && !$past(i_sys_rst)
      |-> o_speed_target == '0 && (o_sleep || o_standby))
      else $error("power-on did not clear target and rest");
   a_wait_zero_target: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == motor_start_pkg::ST_STANDBY) && target_zero
      |=> state_reg == motor_start_pkg::ST_STANDBY)
      else $error("left standby with zero target");
   a_skip_detect: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      (state_reg == motor_start_pkg::ST_SLEEP || state_reg == motor_start_pkg::ST_STANDBY)
      && !target_zero && !i_initial_detect_enable
      |=> state_reg == motor_start_pkg::ST_BRAKE_CHECK)
      else $error("detect disabled but brake check skipped");
   a_detect_pulse: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      $rose(state_reg == motor_start_pkg::ST_DETECT) |-> o_detect_start ##1 !o_detect_start)
      else $error("detect start not a single pulse");
   a_reverse_only: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      state_reg == motor_start_pkg::ST_REV_CHECK && !i_counter_rotation_drive_enable
      && !target_zero |=> state_reg == motor_start_pkg::ST_COAST_CHECK)
      else $error("reverse drive without enable");
   a_fast_catch: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      state_reg == motor_start_pkg::ST_FWD_CHECK && i_forward_catch_enable && !target_zero
      && o_seed_speed > i_forward_catch_speed_threshold
      |=> state_reg == motor_start_pkg::ST_CLOSED_LOOP && o_seed_load ##1 !o_seed_load)
      else $error("fast forward catch missed closed loop");
   a_coast_all_off: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      state_reg == motor_start_pkg::ST_COAST
      |-> o_gate.force_on && o_gate.high_on == 3'h0 && o_gate.low_on == 3'h0)
      else $error("coast left a switch on");
   a_current_brake_low: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      state_reg == motor_start_pkg::ST_BRAKE && i_brake_type_select
      |-> o_gate.low_on == 3'h7 && o_gate.high_on == 3'h0)
      else $error("current brake not on low side");
   a_no_brake_start: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      state_reg == motor_start_pkg::ST_BRAKE_CHECK && !i_brake_enable && !target_zero
      |=> state_reg == motor_start_pkg::ST_STARTUP ##0 o_startup.start)
      else $error("brake disabled but start-up not begun");
   a_closed_foc: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      state_reg == motor_start_pkg::ST_CLOSED_LOOP |-> o_foc_run && !o_open_loop)
      else $error("closed loop without field control");
endmodule

// >>> dv/motor_model.sv
// Behavioural motor and spin detector that answer the start sequencer.
`timescale 1ns/1ps
module motor_model #(
   parameter int LAT = 3
) (
   input wire logic i_sys_clk,
   input wire logic i_detect_start,
   input wire logic i_startup_start,
   input wire logic [15:0] i_spin_speed,
   input wire logic i_spin_reverse,
   output logic o_detect_done,
   output logic [15:0] o_detect_speed,
   output logic o_detect_dir_reverse,
   output logic o_startup_done,
   output logic [15:0] o_speed_estimate,
   output logic o_estimate_dir_reverse
);
   int dcnt = 0;
   int scnt = 0;
   initial begin
      o_detect_done = 1'b0;
      o_detect_speed = 16'h0000;
      o_detect_dir_reverse = 1'b0;
      o_startup_done = 1'b0;
   end
   // Results flip every cycle outside the done pulse, so a stale sample is never a match.
   always @(posedge i_sys_clk) begin
      dcnt <= i_detect_start ? LAT : (dcnt > 0 ? dcnt - 1 : 0);
      scnt <= i_startup_start ? LAT : (scnt > 0 ? scnt - 1 : 0);
      o_detect_done <= (dcnt == 1);
      o_detect_speed <= (dcnt == 1) ? i_spin_speed : ~o_detect_speed;
      o_detect_dir_reverse <= (dcnt == 1) ? i_spin_reverse : ~o_detect_dir_reverse;
      o_startup_done <= (scnt == 1);
   end
   assign o_speed_estimate = i_spin_speed;
   assign o_estimate_dir_reverse = i_spin_reverse;
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the motor start sequencer.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
 $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] tgt = 16'h0000;
   logic [15:0] spin = 16'h0000;
   logic [15:0] dur = 16'h0002;
   logic [15:0] bdur = 16'h0002;
   logic [15:0] pos = 16'h1234;
   logic [11:0] cur = 12'h000;
   logic [1:0] meth = 2'h0;
   logic cdir = 1'b0, pss = 1'b0, wake = 1'b0, det_en = 1'b0, fc_en = 1'b0, rev_rot = 1'b0;
   logic cr_en = 1'b0, co_en = 1'b0, br_en = 1'b0, bt = 1'b0, bside = 1'b0, psel = 1'b0;
   logic d_done, d_rev, s_done, e_rev, slp, stby, d_go, seed, foc, ol, decel, rpar;
   logic [15:0] d_spd, est, tgt_q, seed_spd, seed_pos;
   motor_start_pkg::seq_state_type st;
   motor_start_pkg::gate_ctrl_type gate;
   motor_start_pkg::startup_cmd_type su;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   initial begin
      forever #10 clk = ~clk;
   end
   motor_start_sequencer #(.TICK_CYCLES(4)) u_motor_start_sequencer (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_speed_target(tgt), .i_cmd_dir_reverse(cdir),
      .i_power_state_select(pss), .i_speed_wake_level(wake), .i_initial_detect_enable(det_en),
      .i_forward_catch_enable(fc_en), .i_counter_rotation_drive_enable(cr_en),
      .i_coast_enable(co_en), .i_brake_enable(br_en), .i_brake_type_select(bt),
      .i_brake_switch_side_select(bside), .i_counter_rotation_param_select(psel),
      .i_startup_method_select(meth), .i_forward_catch_speed_threshold(16'h0100),
      .i_loop_handoff_speed_threshold(16'h0080), .i_loop_handoff_speed_level(16'h0100),
      .i_coast_duration(dur), .i_brake_duration(bdur), .i_brake_current_settle_time(dur),
      .i_brake_current_level(12'h100), .i_phase_current_peak(cur), .i_detect_done(d_done),
      .i_detect_speed(d_spd), .i_detect_position(pos), .i_detect_dir_reverse(d_rev),
      .i_startup_done(s_done), .i_speed_estimate(est), .i_estimate_dir_reverse(e_rev),
      .o_state(st), .o_speed_target(tgt_q), .o_sleep(slp), .o_standby(stby),
      .o_detect_start(d_go), .o_seed_load(seed), .o_seed_speed(seed_spd),
      .o_seed_position(seed_pos),
      .o_gate(gate), .o_startup(su), .o_foc_run(foc), .o_open_loop(ol), .o_ramp_decel(decel),
      .o_use_reverse_params(rpar));
   motor_model u_motor_model (
      .i_sys_clk(clk), .i_detect_start(d_go), .i_startup_start(su.start), .i_spin_speed(spin),
      .i_spin_reverse(rev_rot), .o_detect_done(d_done), .o_detect_speed(d_spd),
      .o_detect_dir_reverse(d_rev), .o_startup_done(s_done), .o_speed_estimate(est),
      .o_estimate_dir_reverse(e_rev));
   task automatic finish_test;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end
   // Polls on the falling edge so the first cycle of a new state is the one compared.
   task automatic wait_st(motor_start_pkg::seq_state_type s, int n);
      int i;
      i = 0;
      while (st !== s && i < n) begin
         @(negedge clk);
         i++;
      end
      `CHK(st, s)
   endtask
   task automatic go(logic [15:0] t);
      @(posedge clk);
      tgt <= t;
   endtask
   task automatic t_power;
      @(posedge clk);
      pss <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
      `CHK(st, motor_start_pkg::ST_SLEEP)
      `CHK({slp, tgt_q}, 17'h10000)
      @(posedge clk);
      rst <= 1'b1;
      pss <= 1'b0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (12) @(negedge clk);
      `CHK({stby, st}, {1'b1, motor_start_pkg::ST_STANDBY})
   endtask
   task automatic t_still;
      for (int m = 0; m < 4; m++) begin
         @(posedge clk);
         meth <= m[1:0];
         go(16'h0400);
         wait_st(motor_start_pkg::ST_STARTUP, 10);
         `CHK({su.start, su.method}, {1'b1, m[1:0]})
         wait_st(motor_start_pkg::ST_OPEN_LOOP, 20);
         `CHK(ol, 1'b1)
         go(16'h0000);
         wait_st(motor_start_pkg::ST_STANDBY, 5);
      end
   endtask
   task automatic t_fwd;
      @(posedge clk);
      det_en <= 1'b1;
      fc_en <= 1'b1;
      spin <= 16'h0200;
      go(16'h0400);
      wait_st(motor_start_pkg::ST_DETECT, 5);
      `CHK(d_go, 1'b1)
      wait_st(motor_start_pkg::ST_CLOSED_LOOP, 20);
      `CHK({seed, seed_spd, foc}, {1'b1, 16'h0200, 1'b1})
      `CHK(seed_pos, 16'h1234)
      go(16'h0000);
      wait_st(motor_start_pkg::ST_STANDBY, 5);
      spin <= 16'h0080;
      go(16'h0400);
      wait_st(motor_start_pkg::ST_OPEN_LOOP, 20);
      go(16'h0000);
      wait_st(motor_start_pkg::ST_STANDBY, 5);
   endtask
   task automatic t_rev;
      @(posedge clk);
      cdir <= 1'b1;
      cr_en <= 1'b1;
      psel <= 1'b1;
      spin <= 16'h0200;
      go(16'h0400);
      wait_st(motor_start_pkg::ST_REV_CLOSED, 20);
      `CHK({decel, rpar, foc}, 3'h7)
      spin <= 16'h0040;
      wait_st(motor_start_pkg::ST_REV_OPEN, 5);
      `CHK({ol, decel}, 2'h3)
      @(posedge clk);
      rev_rot <= 1'b1;
      spin <= 16'h0200;
      wait_st(motor_start_pkg::ST_CLOSED_LOOP, 5);
      `CHK(rpar, 1'b0)
      go(16'h0000);
      wait_st(motor_start_pkg::ST_STANDBY, 5);
      rev_rot <= 1'b0;
      cr_en <= 1'b0;
      go(16'h0400);
      wait_st(motor_start_pkg::ST_STARTUP, 20);
      go(16'h0000);
      wait_st(motor_start_pkg::ST_STANDBY, 5);
   endtask
   task automatic t_brake;
      @(posedge clk);
      cdir <= 1'b0;
      fc_en <= 1'b0;
      co_en <= 1'b1;
      br_en <= 1'b1;
      bside <= 1'b1;
      go(16'h0400);
      wait_st(motor_start_pkg::ST_COAST, 20);
      `CHK(gate, 7'h40)
      repeat (6) @(negedge clk);
      `CHK(st, motor_start_pkg::ST_COAST)
      wait_st(motor_start_pkg::ST_BRAKE, 40);
      `CHK(gate, 7'h78)
      wait_st(motor_start_pkg::ST_STARTUP, 40);
      go(16'h0000);
      wait_st(motor_start_pkg::ST_STANDBY, 5);
      co_en <= 1'b0;
      bt <= 1'b1;
      cur <= 12'hFFF;
      go(16'h0400);
      wait_st(motor_start_pkg::ST_BRAKE, 20);
      `CHK(gate, 7'h47)
      repeat (6) @(negedge clk);
      `CHK(st, motor_start_pkg::ST_BRAKE)
      wait_st(motor_start_pkg::ST_STARTUP, 40);
      go(16'h0000);
      wait_st(motor_start_pkg::ST_STANDBY, 5);
      cur <= 12'h000;
      bdur <= 16'h0010;
      go(16'h0400);
      wait_st(motor_start_pkg::ST_BRAKE, 20);
      wait_st(motor_start_pkg::ST_STARTUP, 14);
   endtask
   initial begin
      t_power();
      t_still();
      t_fwd();
      t_rev();
      t_brake();
      finish_test();
   end
endmodule
